// ---- verilog/mem_device_end.sv ----
// Memory device end: command decode, power states, lanes, status
module mem_device_end (
	// Link pins
	mem_link_if.device link,
	// User clock domain
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Status, user clock domain
	output logic power_down_o,
	output logic self_refresh_o,
	output logic termination_on_o,
	output logic [3:0] open_banks_o,
	output logic [12:0] mode_word_o,
	output logic [12:0] ext_mode_word_o
);

	logic [3:0] hold_cnt;
	logic link_rst_n;
	logic rst_meta;
	logic rst_sync;
	logic cke_prev;
	mem_link_pkg::power_type power_state;
	logic term_applied;
	logic [3:0] cmd_code;
	logic cmd_ok;
	logic [3:0] bank_open;
	logic [3:0] row_sel;
	logic [12:0] mode_reg;
	logic [12:0] ext_one_reg;
	logic [1:0] rd_left;
	logic [1:0] wr_left;
	logic [1:0] burst_bank;
	logic burst_row;
	logic [1:0] burst_beat;
	logic burst_ap;
	logic ap_close;
	logic wr_commit;
	logic rd_oe;
	logic [4:0] even_idx;
	logic [4:0] odd_idx;
	logic [4:0] odd_idx_q;
	wire [15:0] rd_word;
	logic [32:0] status_link;
	wire [32:0] status_sync;

	// Link clock is stopped in reset, so stretch reset past release
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			hold_cnt <= 4'h0;
			link_rst_n <= 1'b0;
		end else if (ce_i) begin
			if (hold_cnt != mem_link_pkg::LINK_RST_HOLD) begin
				hold_cnt <= hold_cnt + 4'h1;
			end
			link_rst_n <= (hold_cnt == mem_link_pkg::LINK_RST_HOLD);
		end
	end

	// Reset brought into the link clock domain
	always_ff @(posedge link.ck) begin
		rst_meta <= link_rst_n;
		rst_sync <= rst_meta;
	end

	assign cmd_code = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
	assign cmd_ok = cke_prev && link.cke && !link.cs_n
		&& (power_state == mem_link_pkg::PWR_ACTIVE);

	always_ff @(posedge link.ck) begin
		if (!rst_sync) begin
			cke_prev <= 1'b0;
			power_state <= mem_link_pkg::PWR_ACTIVE;
		end else begin
			cke_prev <= link.cke;
			if (cke_prev && !link.cke) begin
				if (bank_open != 4'h0) begin
					power_state <= mem_link_pkg::PWR_ACT_DOWN;
				end else if (cmd_code == mem_link_pkg::CODE_REFRESH) begin
					power_state <= mem_link_pkg::PWR_SELF_REF;
				end else begin
					power_state <= mem_link_pkg::PWR_PRE_DOWN;
				end
			end else if (!cke_prev && link.cke) begin
				power_state <= mem_link_pkg::PWR_ACTIVE;
			end
		end
	end

	always_ff @(posedge link.ck) begin
		if (!rst_sync) begin
			term_applied <= 1'b0;
		end else begin
			term_applied <= link.termination_control
				&& (power_state != mem_link_pkg::PWR_SELF_REF);
		end
	end

	always_ff @(posedge link.ck) begin
		if (!rst_sync) begin
			bank_open <= 4'h0;
			row_sel <= 4'h0;
			mode_reg <= mem_link_pkg::MODE_RESET;
			ext_one_reg <= mem_link_pkg::EXT_ONE_RESET;
		end else begin
			if (ap_close) begin
				bank_open[burst_bank] <= 1'b0;
			end
			if (cmd_ok) begin
				unique case (cmd_code)
					mem_link_pkg::CODE_ACTIVATE: begin
						bank_open[link.ba] <= 1'b1;
						row_sel[link.ba] <= link.addr[mem_link_pkg::ROW_SEL_BIT];
					end
					mem_link_pkg::CODE_PRECHARGE: begin
						if (link.addr[mem_link_pkg::PRECHARGE_SCOPE_BIT]) begin
							bank_open <= 4'h0;
						end else begin
							bank_open[link.ba] <= 1'b0;
						end
					end
					mem_link_pkg::CODE_MODE_WRITE: begin
						if (link.ba == mem_link_pkg::SEL_BASE_MODE) begin
							mode_reg <= link.addr;
						end else if (link.ba == mem_link_pkg::SEL_EXT_ONE) begin
							ext_one_reg <= link.addr;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Burst sequencing for reads and writes
	always_ff @(posedge link.ck) begin
		if (!rst_sync) begin
			rd_left <= 2'h0;
			wr_left <= 2'h0;
			burst_bank <= 2'h0;
			burst_row <= 1'b0;
			burst_beat <= 2'h0;
			burst_ap <= 1'b0;
		end else if (cmd_ok && (cmd_code == mem_link_pkg::CODE_READ
				|| cmd_code == mem_link_pkg::CODE_WRITE)) begin
			burst_bank <= link.ba;
			burst_row <= row_sel[link.ba];
			burst_beat <= {link.addr[mem_link_pkg::COL_PAIR_BIT], 1'b0};
			burst_ap <= link.addr[mem_link_pkg::AUTO_PRECHARGE_BIT];
			if (cmd_code == mem_link_pkg::CODE_READ) begin
				rd_left <= mem_link_pkg::READ_PAIRS;
				wr_left <= 2'h0;
			end else begin
				wr_left <= mem_link_pkg::WRITE_START;
				rd_left <= 2'h0;
			end
		end else begin
			if (rd_left != 2'h0) begin
				rd_left <= rd_left - 2'h1;
				burst_beat <= burst_beat + 2'h2;
			end
			if (wr_left != 2'h0) begin
				wr_left <= wr_left - 2'h1;
			end
			if (wr_commit) begin
				burst_beat <= burst_beat + 2'h2;
			end
		end
	end

	assign wr_commit = (wr_left != 2'h0)
		&& (wr_left <= mem_link_pkg::WRITE_LAST_PAIR);
	assign ap_close = burst_ap && ((rd_left == 2'h1) || (wr_left == 2'h1));
	assign even_idx = {burst_bank, burst_row, burst_beat};
	assign odd_idx = {burst_bank, burst_row, burst_beat[1], 1'b1};

	always_ff @(posedge link.ck) begin
		if (!rst_sync) begin
			rd_oe <= 1'b0;
			odd_idx_q <= 5'h00;
		end else begin
			rd_oe <= (rd_left != 2'h0);
			odd_idx_q <= odd_idx;
		end
	end

	for (genvar g = 0; g < mem_link_pkg::LANES; g++) begin : lane_gen
		logic [7:0] cap_even;
		logic [7:0] cap_odd;
		logic mask_even;
		logic mask_odd;
		logic [7:0] lane_mem [mem_link_pkg::STORE_DEPTH];
		logic [7:0] out_even;
		logic [7:0] out_odd;

		// mask sampled on both strobe edges
		always_ff @(posedge link.lane_strobe[g]) begin
			cap_even <= link.dq[g*8 +: 8];
			mask_even <= link.write_mask[g];
		end
		always_ff @(negedge link.lane_strobe[g]) begin
			cap_odd <= link.dq[g*8 +: 8];
			mask_odd <= link.write_mask[g];
		end

		always_ff @(posedge link.ck) begin
			if (wr_commit) begin
				if (!mask_even) begin
					lane_mem[even_idx] <= cap_even;
				end
				if (!mask_odd) begin
					lane_mem[odd_idx] <= cap_odd;
				end
			end
		end

		always_ff @(posedge link.ck) begin
			if (rd_left != 2'h0) begin
				out_even <= lane_mem[even_idx];
			end
		end
		always_ff @(negedge link.ck) begin
			out_odd <= lane_mem[odd_idx_q];
		end
		assign rd_word[g*8 +: 8] = link.ck ? out_even : out_odd;
	end

	assign link.dev_dq = rd_word;
	assign link.dev_dq_oe = rd_oe;
	assign link.dev_strobe = {2{link.ck}};
	assign link.dev_strobe_n = {2{~link.ck}};
	assign link.dev_strobe_oe = rd_oe;
	assign link.dev_strobe_n_oe = rd_oe
		&& !ext_one_reg[mem_link_pkg::STROBE_MODE_BIT];

	always_comb begin
		status_link = {ext_one_reg, mode_reg, bank_open, term_applied,
			power_state == mem_link_pkg::PWR_SELF_REF,
			power_state == mem_link_pkg::PWR_PRE_DOWN
			|| power_state == mem_link_pkg::PWR_ACT_DOWN};
	end

	// Status levels into the user domain, three stages per bit
	for (genvar s = 0; s < mem_link_pkg::STATUS_W; s++) begin : sync_gen
		logic s1;
		logic s2;
		logic s3;
		logic held;

		always_ff @(posedge clk_i) begin
			if (!nrst_i) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				held <= 1'b0;
			end else if (ce_i) begin
				s1 <= status_link[s];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					held <= s3;
				end
			end
		end
		assign status_sync[s] = held;
	end

	assign power_down_o = status_sync[0];
	assign self_refresh_o = status_sync[1];
	assign termination_on_o = status_sync[2];
	assign open_banks_o = status_sync[6:3];
	assign mode_word_o = status_sync[19:7];
	assign ext_mode_word_o = status_sync[32:20];

endmodule : mem_device_end

// ---- include/mem_link_pkg.sv ----
// Shared constants and types for both ends of the memory pin link
package mem_link_pkg;

	// Widths and counts
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int DQ_W = 16;
	localparam int BEATS = 4;
	localparam int BURST_W = 64;
	localparam int MASK_W = 8;
	localparam int STORE_DEPTH = 32;
	localparam int STORE_IDX_W = 5;
	localparam int STATUS_W = 33;

	// Command codes {chip select, row strobe, column strobe, write enable}
	localparam logic [3:0] CODE_MODE_WRITE = 4'h0;
	localparam logic [3:0] CODE_REFRESH = 4'h1;
	localparam logic [3:0] CODE_PRECHARGE = 4'h2;
	localparam logic [3:0] CODE_ACTIVATE = 4'h3;
	localparam logic [3:0] CODE_WRITE = 4'h4;
	localparam logic [3:0] CODE_READ = 4'h5;
	localparam logic [3:0] CODE_NOP = 4'h7;
	localparam logic [3:0] CODE_DESELECT = 4'hF;

	// Address field positions
	localparam int PRECHARGE_SCOPE_BIT = 10;
	localparam int AUTO_PRECHARGE_BIT = 10;
	localparam int STROBE_MODE_BIT = 10;
	localparam int COL_PAIR_BIT = 1;
	localparam int ROW_SEL_BIT = 0;

	// Mode register targets and reset values
	localparam logic [1:0] SEL_BASE_MODE = 2'h0;
	localparam logic [1:0] SEL_EXT_ONE = 2'h1;
	localparam logic [12:0] MODE_RESET = 13'h0000;
	localparam logic [12:0] EXT_ONE_RESET = 13'h0000;

	// Burst sequencing in link cycles
	localparam logic [1:0] READ_PAIRS = 2'h2;
	localparam logic [1:0] WRITE_START = 2'h3;
	localparam logic [1:0] WRITE_LAST_PAIR = 2'h2;

	// User clocks that link reset is held after release
	localparam logic [3:0] LINK_RST_HOLD = 4'hC;

	// Link clock derived from the user clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int LINK_PERIOD_PS = 16000;
	localparam int LINK_DIV = LINK_PERIOD_PS / CLK_PERIOD_PS;
	localparam logic [1:0] PHASE_LAST = 2'(LINK_DIV - 1);

	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_MODE_WRITE,
		CMD_REFRESH,
		CMD_SELF_REFRESH,
		CMD_POWER_DOWN,
		CMD_WAKE
	} cmd_type;

	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_PRE_DOWN,
		PWR_ACT_DOWN,
		PWR_SELF_REF
	} power_type;

	typedef enum logic [1:0] {
		CTL_IDLE,
		CTL_READ,
		CTL_WRITE
	} ctl_type;

endpackage : mem_link_pkg

// ---- include/mem_link_if.sv ----
// Pin bundle between the controller end and the memory device end
interface mem_link_if;
	logic ck;
	logic ck_n;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [12:0] addr;
	logic termination_control;
	logic [1:0] write_mask;
	logic [15:0] ctl_dq;
	logic ctl_dq_oe;
	logic [1:0] ctl_strobe;
	logic [1:0] ctl_strobe_n;
	logic ctl_strobe_oe;
	logic [15:0] dev_dq;
	logic dev_dq_oe;
	logic [1:0] dev_strobe;
	logic [1:0] dev_strobe_n;
	logic dev_strobe_oe;
	logic dev_strobe_n_oe;
	logic [15:0] dq;
	logic [1:0] lane_strobe;
	logic [1:0] lane_strobe_n;

	// Wire levels resolved from the drive enables
	assign dq = dev_dq_oe ? dev_dq : ctl_dq;
	assign lane_strobe = dev_strobe_oe ? dev_strobe : ctl_strobe;
	assign lane_strobe_n = dev_strobe_n_oe ? dev_strobe_n : ctl_strobe_n;

	modport controller (
		output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		output termination_control, write_mask,
		output ctl_dq, ctl_dq_oe, ctl_strobe, ctl_strobe_n, ctl_strobe_oe,
		input dq, lane_strobe
	);

	modport device (
		input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		input termination_control, write_mask, dq, lane_strobe,
		output dev_dq, dev_dq_oe, dev_strobe, dev_strobe_n,
		output dev_strobe_oe, dev_strobe_n_oe
	);
endinterface : mem_link_if

// ---- verilog/mem_controller_end.sv ----
// Controller end: link clock divider, command issue, burst data
module mem_controller_end (
	// Link pins
	mem_link_if.controller link,
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Command request
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire mem_link_pkg::cmd_type cmd_i,
	input wire logic [1:0] bank_i,
	input wire logic [12:0] addr_i,
	input wire logic [63:0] wdata_i,
	input wire logic [7:0] wmask_i,
	// Read return
	output logic rdata_valid_o,
	output logic [63:0] rdata_o
);

	logic [1:0] phase;
	logic ck_q;
	mem_link_pkg::ctl_type state;
	logic [1:0] k;
	logic issue;
	logic cke_q;
	logic [3:0] code_q;
	logic [1:0] ba_q;
	logic [12:0] addr_q;
	logic [63:0] wdata_q;
	logic [7:0] wmask_q;
	logic [15:0] dq_q;
	logic dq_oe_q;
	logic [1:0] dm_q;
	logic strobe_q;
	logic term_q;
	logic [63:0] rdata_q;
	logic rvalid_q;
	logic load_beat;
	logic [1:0] next_beat;

	// Link clock divided from the user clock
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			phase <= 2'h0;
			ck_q <= 1'b0;
		end else if (ce_i) begin
			phase <= phase + 2'h1;
			ck_q <= (phase == mem_link_pkg::PHASE_LAST) || (phase == 2'h0);
		end
	end

	// bursts only with clock enable high
	assign cmd_ready_o = ce_i && (phase == 2'h1)
		&& (state == mem_link_pkg::CTL_IDLE)
		&& (cke_q || cmd_i == mem_link_pkg::CMD_WAKE);
	assign issue = cmd_ready_o && cmd_valid_i;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cke_q <= 1'b0;
			code_q <= mem_link_pkg::CODE_DESELECT;
			ba_q <= 2'h0;
			addr_q <= 13'h0000;
		end else if (ce_i && phase == 2'h1) begin
			code_q <= mem_link_pkg::CODE_DESELECT;
			if (issue) begin
				ba_q <= bank_i;
				addr_q <= addr_i;
				unique case (cmd_i)
					mem_link_pkg::CMD_ACTIVATE: code_q <= mem_link_pkg::CODE_ACTIVATE;
					mem_link_pkg::CMD_READ: code_q <= mem_link_pkg::CODE_READ;
					mem_link_pkg::CMD_WRITE: code_q <= mem_link_pkg::CODE_WRITE;
					mem_link_pkg::CMD_PRECHARGE: code_q <= mem_link_pkg::CODE_PRECHARGE;
					mem_link_pkg::CMD_MODE_WRITE: code_q <= mem_link_pkg::CODE_MODE_WRITE;
					mem_link_pkg::CMD_REFRESH: code_q <= mem_link_pkg::CODE_REFRESH;
					mem_link_pkg::CMD_SELF_REFRESH: begin
						code_q <= mem_link_pkg::CODE_REFRESH;
						cke_q <= 1'b0;
					end
					mem_link_pkg::CMD_POWER_DOWN: begin
						code_q <= mem_link_pkg::CODE_NOP;
						cke_q <= 1'b0;
					end
					mem_link_pkg::CMD_WAKE: begin
						code_q <= mem_link_pkg::CODE_NOP;
						cke_q <= 1'b1;
					end
					default: code_q <= mem_link_pkg::CODE_NOP;
				endcase
			end
		end
	end

	// Burst sequencer, k counts link cycles after issue
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state <= mem_link_pkg::CTL_IDLE;
			k <= 2'h0;
			wdata_q <= 64'h0;
			wmask_q <= 8'h00;
		end else if (ce_i) begin
			if (issue && cmd_i == mem_link_pkg::CMD_READ) begin
				state <= mem_link_pkg::CTL_READ;
				k <= 2'h0;
			end else if (issue && cmd_i == mem_link_pkg::CMD_WRITE) begin
				state <= mem_link_pkg::CTL_WRITE;
				k <= 2'h0;
				wdata_q <= wdata_i;
				wmask_q <= wmask_i;
			end else if (state != mem_link_pkg::CTL_IDLE
					&& phase == mem_link_pkg::PHASE_LAST) begin
				k <= k + 2'h1;
				if (k == 2'h3) begin
					state <= mem_link_pkg::CTL_IDLE;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_q <= 64'h0;
			rvalid_q <= 1'b0;
		end else if (ce_i) begin
			rvalid_q <= (state == mem_link_pkg::CTL_READ) && (k == 2'h3)
				&& (phase == mem_link_pkg::PHASE_LAST);
			if (state == mem_link_pkg::CTL_READ && k[1] && phase[0]) begin
				rdata_q[{k[0], phase[1], 4'h0} +: 16] <= link.dq;
			end
		end
	end

	assign next_beat = (phase == mem_link_pkg::PHASE_LAST)
		? {~k[0], 1'b0} : {k[0], 1'b1};
	assign load_beat = (state == mem_link_pkg::CTL_WRITE)
		&& (((phase == mem_link_pkg::PHASE_LAST) && (k == 2'h1 || k == 2'h2))
		|| ((phase == 2'h1) && k[1]));

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			dq_q <= 16'h0000;
			dq_oe_q <= 1'b0;
			dm_q <= 2'h0;
			strobe_q <= 1'b0;
			term_q <= 1'b0;
		end else if (ce_i) begin
			term_q <= (state == mem_link_pkg::CTL_WRITE);
			if (load_beat) begin
				dq_q <= wdata_q[{next_beat, 4'h0} +: 16];
				dm_q <= wmask_q[{next_beat, 1'b0} +: 2];
			end
			if (state == mem_link_pkg::CTL_WRITE
					&& phase == mem_link_pkg::PHASE_LAST) begin
				dq_oe_q <= (k != 2'h3);
			end
			if (dq_oe_q && phase == 2'h0) begin
				strobe_q <= 1'b1;
			end else if (phase == 2'h2) begin
				strobe_q <= 1'b0;
			end
		end
	end

	assign link.ck = ck_q;
	assign link.ck_n = ~ck_q;
	assign link.cke = cke_q;
	assign link.cs_n = code_q[3];
	assign link.ras_n = code_q[2];
	assign link.cas_n = code_q[1];
	assign link.we_n = code_q[0];
	assign link.ba = ba_q;
	assign link.addr = addr_q;
	assign link.termination_control = term_q;
	assign link.write_mask = dm_q;
	assign link.ctl_dq = dq_q;
	assign link.ctl_dq_oe = dq_oe_q;
	assign link.ctl_strobe = {2{strobe_q}};
	assign link.ctl_strobe_n = {2{~strobe_q}};
	assign link.ctl_strobe_oe = dq_oe_q;
	assign rdata_o = rdata_q;
	assign rdata_valid_o = rvalid_q;

endmodule : mem_controller_end

// ---- tb/mem_link_monitor.sv ----
// Concurrent checks on the pins joining the controller and device ends
module mem_link_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Command pins
	input wire logic ck,
	input wire logic ck_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [12:0] addr,
	input wire logic termination_control,
	// Data drive pins
	input wire logic ctl_dq_oe,
	input wire logic ctl_strobe_oe,
	input wire logic dev_dq_oe,
	input wire logic [1:0] dev_strobe,
	input wire logic [1:0] dev_strobe_n,
	input wire logic dev_strobe_oe,
	input wire logic dev_strobe_n_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] code;
	logic [5:0] since_rst;
	assign code = {cs_n, ras_n, cas_n, we_n};
	// Device link side comes out of reset some cycles after release
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			since_rst <= 6'h00;
		end else if (since_rst != 6'h3F) begin
			since_rst <= since_rst + 6'h01;
		end
	end
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i || since_rst != 6'h3F);

	ck_toggle_a: assert property ($rose(ck) |=> ck ##1 !ck ##1 !ck ##1 ck)
		else $error("link clock period wrong");
	ck_pair_a: assert property (ck_n == !ck)
		else $error("link clock pair not complementary");
	cmd_hold_a: assert property ($rose(ck) |-> $stable({code, ba, addr}))
		else $error("command pins move at clock rise");
	cke_sync_a: assert property ($rose(ck) |-> $stable(cke))
		else $error("clock enable moves at clock rise");
	cke_burst_a: assert property ((dev_dq_oe || ctl_dq_oe) |-> cke)
		else $error("clock enable low during burst");
	bus_fight_a: assert property (!(dev_dq_oe && (ctl_dq_oe || ctl_strobe_oe)))
		else $error("both ends drive data");
	read_turn_a: assert property (
		$rose(ck) && cke && code == mem_link_pkg::CODE_READ |-> ##[3:5] dev_dq_oe)
		else $error("read data not driven");
	write_turn_a: assert property ($rose(ck) && code == mem_link_pkg::CODE_WRITE
		|-> ##[2:4] ctl_dq_oe && termination_control)
		else $error("write data not driven");
	read_strobe_a: assert property (dev_strobe_oe |-> dev_strobe == {2{ck}})
		else $error("read strobe not edge aligned");
	strobe_pair_a: assert property (dev_strobe_n_oe
		|-> dev_strobe_oe && dev_strobe_n == ~dev_strobe)
		else $error("complement strobe wrong");
	quiet_idle_a: assert property (!cke |-> !dev_dq_oe && !dev_strobe_oe)
		else $error("device drives in power state");
endmodule : mem_link_monitor

// ---- tb/tb_top.sv ----
// Self-checking bench joining the controller and device ends
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		mem_link_pkg::cmd_type c;
		logic [1:0] b;
		logic [12:0] a;
		logic [3:0] ob;
		logic pd;
		logic sr;
	} row_type;
	localparam logic [63:0] PAT_A = 64'h0123456789ABCDEF;
	localparam logic [63:0] PAT_B = 64'hFEDCBA9876543210;
	localparam logic [7:0] MASK_B = 8'h06;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cmd_valid = 1'b0;
	mem_link_pkg::cmd_type cmd = mem_link_pkg::CMD_NOP;
	logic [1:0] bank = 2'h0;
	logic [12:0] addr = 13'h0000;
	logic [63:0] wdata = 64'h0;
	logic [7:0] wmask = 8'h00;
	logic cmd_ready, rd_valid, pd, sr, term;
	logic [3:0] banks;
	logic [12:0] mode, ext_mode;
	logic [63:0] rdata, exp_rd;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_term = 0;
	int n_neg = 0;
	int n_rv = 0;
	int t0, t1;
	row_type rows [14];
	mem_link_if link ();

	mem_controller_end mem_controller_end_i (.link(link.controller),
		.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd),
		.bank_i(bank), .addr_i(addr), .wdata_i(wdata), .wmask_i(wmask),
		.rdata_valid_o(rd_valid), .rdata_o(rdata));
	mem_device_end mem_device_end_i (.link(link.device),
		.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.power_down_o(pd), .self_refresh_o(sr), .termination_on_o(term),
		.open_banks_o(banks), .mode_word_o(mode),
		.ext_mode_word_o(ext_mode));
	mem_link_monitor mem_link_monitor_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.ck(link.ck), .ck_n(link.ck_n), .cke(link.cke), .cs_n(link.cs_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.ba(link.ba), .addr(link.addr),
		.termination_control(link.termination_control),
		.ctl_dq_oe(link.ctl_dq_oe), .ctl_strobe_oe(link.ctl_strobe_oe),
		.dev_dq_oe(link.dev_dq_oe), .dev_strobe(link.dev_strobe),
		.dev_strobe_n(link.dev_strobe_n), .dev_strobe_oe(link.dev_strobe_oe),
		.dev_strobe_n_oe(link.dev_strobe_n_oe));

	always #2 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		n_term <= n_term + int'(term === 1'b1);
		n_neg <= n_neg + int'(link.dev_strobe_n_oe === 1'b1);
		n_rv <= n_rv + int'(rd_valid === 1'b1);
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk_cnt(input int got, input int exp, input string what);
		n_tests++;
		if (got != exp) begin
			n_fail++;
			$display("Error %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask : chk_cnt

	// Hold request until ready, then let the link and status settle
	task automatic issue(input mem_link_pkg::cmd_type c, input logic [1:0] b,
		input logic [12:0] a, input logic [63:0] wd, input logic [7:0] wm);
		int k;
		@(posedge clk_i);
		cmd_valid <= 1'b1;
		cmd <= c;
		bank <= b;
		addr <= a;
		wdata <= wd;
		wmask <= wm;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (cmd_ready !== 1'b1 && k < 40);
		@(posedge clk_i);
		cmd_valid <= 1'b0;
		repeat (24) @(posedge clk_i);
		@(negedge clk_i);
	endtask : issue

	initial begin
		rows = '{
			'{mem_link_pkg::CMD_WAKE, 2'h0, 13'h0000, 4'h0, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_ACTIVATE, 2'h0, 13'h0000, 4'h1, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_ACTIVATE, 2'h3, 13'h0000, 4'h9, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_PRECHARGE, 2'h3, 13'h0000, 4'h1, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_ACTIVATE, 2'h2, 13'h0000, 4'h5, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 4'h0, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_POWER_DOWN, 2'h0, 13'h0000, 4'h0, 1'b1, 1'b0},
			'{mem_link_pkg::CMD_WAKE, 2'h0, 13'h0000, 4'h0, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_ACTIVATE, 2'h1, 13'h0000, 4'h2, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_POWER_DOWN, 2'h0, 13'h0000, 4'h2, 1'b1, 1'b0},
			'{mem_link_pkg::CMD_WAKE, 2'h0, 13'h0000, 4'h2, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_PRECHARGE, 2'h1, 13'h0400, 4'h0, 1'b0, 1'b0},
			'{mem_link_pkg::CMD_SELF_REFRESH, 2'h0, 13'h0000, 4'h0, 1'b0, 1'b1},
			'{mem_link_pkg::CMD_WAKE, 2'h0, 13'h0000, 4'h0, 1'b0, 1'b0}};
		repeat (6) @(posedge clk_i);
		chk(64'({mode, ext_mode, banks, pd, sr}), 64'h0, "reset state");
		nrst_i <= 1'b1;
		foreach (rows[i]) begin
			issue(rows[i].c, rows[i].b, rows[i].a, 64'h0, 8'h00);
			chk(64'(banks), 64'(rows[i].ob), "open banks");
			chk(64'({pd, sr}), 64'({rows[i].pd, rows[i].sr}), "power");
			chk(64'(term), 64'h0, "idle termination");
		end
		issue(mem_link_pkg::CMD_MODE_WRITE, 2'h0, 13'h0123, 64'h0, 8'h00);
		chk(64'({mode, ext_mode}), 64'h0000000000246000, "base mode");
		issue(mem_link_pkg::CMD_MODE_WRITE, 2'h2, 13'h1FFF, 64'h0, 8'h00);
		chk(64'({mode, ext_mode}), 64'h0000000000246000, "other sel");
		issue(mem_link_pkg::CMD_ACTIVATE, 2'h1, 13'h0000, 64'h0, 8'h00);
		t0 = n_term;
		issue(mem_link_pkg::CMD_WRITE, 2'h1, 13'h0000, PAT_A, 8'h00);
		issue(mem_link_pkg::CMD_WRITE, 2'h1, 13'h0000, PAT_B, MASK_B);
		chk_cnt(int'(n_term > t0), 1, "termination in write");
		for (int i = 0; i < 8; i++) begin
			exp_rd[8*i+:8] = MASK_B[i] ? PAT_A[8*i+:8] : PAT_B[8*i+:8];
		end
		t0 = n_rv;
		t1 = n_neg;
		issue(mem_link_pkg::CMD_READ, 2'h1, 13'h0400, 64'h0, 8'h00);
		chk(rdata, exp_rd, "masked read");
		chk_cnt(n_rv - t0, 1, "valid pulse");
		chk(64'(banks), 64'h0, "auto precharge");
		chk_cnt(int'(n_neg > t1), 1, "differential strobe");
		issue(mem_link_pkg::CMD_MODE_WRITE, 2'h1, 13'h0400, 64'h0, 8'h00);
		chk(64'(ext_mode), 64'h0400, "extended mode");
		issue(mem_link_pkg::CMD_ACTIVATE, 2'h1, 13'h0000, 64'h0, 8'h00);
		t1 = n_neg;
		issue(mem_link_pkg::CMD_READ, 2'h1, 13'h0002, 64'h0, 8'h00);
		chk(rdata, {exp_rd[31:0], exp_rd[63:32]}, "column start");
		chk_cnt(n_neg - t1, 0, "single ended strobe");
		chk(64'(banks), 64'h2, "bank stays open");
		give_verdict();
	end
endmodule : tb_top
